// >>> design/btd_pkg.sv
// Package: constants and types for the block texture channel decoder
// =====================================================================
package btd_pkg;
   // =================================================================
   // Formats
   typedef enum logic [1:0]
   {
      unsigned_single_channel_format = 2'b00,
      signed_single_channel_format = 2'b01,
      unsigned_dual_channel_format = 2'b10,
      signed_dual_channel_format = 2'b11
   } btd_fmt_e;
   // =================================================================
   // Geometry and widths
   localparam int BTD_TILE_DIM = 4;
   localparam logic [4:0] BTD_SMALL_BLOCK_BYTES = 5'h08;
   localparam logic [4:0] BTD_LARGE_BLOCK_BYTES = 5'h10;
   localparam int BTD_DIM_W = 14;
   localparam int BTD_ADDR_W = 32;
   localparam int BTD_CH_W = 16;
   // Output channel: signed Q1.14 fixed point, 1.0 = 16384
   localparam logic signed [15:0] BTD_ONE = 16'sh4000;
   localparam logic signed [15:0] BTD_NEG_ONE = -16'sh4000;
   localparam logic signed [15:0] BTD_ZERO = 16'sh0000;
   localparam logic signed [8:0] BTD_SIGNED_MAX = 9'sh07F;
   localparam logic [7:0] BTD_SIGNED_MIN_BYTE = 8'h80;
   localparam logic [7:0] BTD_UNSIGNED_MAX = 8'hFF;
   localparam logic signed [7:0] BTD_DIV7 = 8'sh07;
   localparam logic signed [7:0] BTD_DIV5 = 8'sh05;
   localparam int BTD_FIFO_DEPTH = 8;
   localparam int BTD_REQ_W = 128 + 2 + 2 + 2;
   localparam int BTD_RES_W = 4 * BTD_CH_W;
endpackage : btd_pkg

// >>> design/btd_decoder.sv
// Module: block texture channel decoder with result FIFO
`timescale 1ns/10ps
// =====================================================================
// FIFO with valid/ready on both sides
module btd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } btd_fifo_s;
   btd_fifo_s st_r;
   btd_fifo_s st_nxt;
   logic [WIDTH-1:0] mem [DEPTH]; // Storage words
   logic push;
   logic pop;
   assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data = mem[st_r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // Pointer and count update
   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop)
      begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   // Storage has no reset; only written words are ever read
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[st_r.wp] <= in_data;
      end
   end
endmodule : btd_fifo

// =====================================================================
// Decoder top: one registered decode stage, then FIFO
module btd_decoder
   import btd_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [127:0] req_block,
   input wire logic [1:0] req_format,
   input wire logic [1:0] req_local_x,
   input wire logic [1:0] req_local_y,
   output logic res_valid,
   input wire logic res_ready,
   output logic [15:0] res_red,
   output logic [15:0] res_green,
   output logic [15:0] res_blue,
   output logic [15:0] res_alpha,
   input wire logic [BTD_DIM_W-1:0] addr_width,
   input wire logic [BTD_DIM_W-1:0] addr_height,
   input wire logic [BTD_DIM_W-1:0] addr_x,
   input wire logic [BTD_DIM_W-1:0] addr_y,
   input wire logic addr_dual,
   output logic [BTD_ADDR_W-1:0] tile_offset,
   output logic [BTD_ADDR_W-1:0] image_bytes,
   output logic [1:0] tile_local_x,
   output logic [1:0] tile_local_y
);
   // ==================================================================
   // Functions
   // Tiles across one dimension, rounded up
   function automatic logic [BTD_DIM_W-1:0] tiles(
      input logic [BTD_DIM_W-1:0] d);
      tiles = (d >> 2) + {{(BTD_DIM_W-1){1'b0}}, (d[1:0] != 2'b00)};
   endfunction : tiles

   // Endpoint byte to Q1.14 value
   function automatic logic signed [15:0] endpoint(
      input logic [7:0] b,
      input logic sgn);
      logic signed [23:0] t;
      t = '0;
      if (!sgn)
      begin
         t = (24'(b) * 24'(BTD_ONE) + 24'(BTD_UNSIGNED_MAX) / 2)
            / 24'(BTD_UNSIGNED_MAX);
         endpoint = t[15:0];
      end
      else if (b == BTD_SIGNED_MIN_BYTE)
      begin
         endpoint = BTD_NEG_ONE;
      end
      else
      begin
         // Round half away from zero, identical every time
         t = 24'(signed'(b)) * 24'(BTD_ONE);
         if (t < 0)
            t = (t - 24'(BTD_SIGNED_MAX) / 2) / 24'(BTD_SIGNED_MAX);
         else
            t = (t + 24'(BTD_SIGNED_MAX) / 2) / 24'(BTD_SIGNED_MAX);
         endpoint = t[15:0];
      end
   endfunction : endpoint

   // Decode one 64-bit channel block for a local texel
   function automatic logic signed [15:0] channel(
      input logic [63:0] blk,
      input logic sgn,
      input logic [1:0] lx,
      input logic [1:0] ly);
      logic [7:0] b0;
      logic [7:0] b1;
      logic [47:0] sel;
      logic [2:0] code;
      logic [5:0] pos;
      logic seven;
      logic signed [15:0] e0;
      logic signed [15:0] e1;
      logic signed [23:0] acc;
      logic signed [7:0] den;
      logic signed [7:0] w0;
      logic signed [7:0] w1;
      b0 = blk[7:0];
      b1 = blk[15:8];
      sel = blk[63:16];
      pos = 6'(3 * {ly, lx});
      code = sel[pos +: 3];
      // Compare raw bytes as the format demands; -127/-128 left as-is
      if (sgn)
         seven = signed'(b0) > signed'(b1);
      else
         seven = b0 > b1;
      e0 = endpoint(b0, sgn);
      e1 = endpoint(b1, sgn);
      den = seven ? BTD_DIV7 : BTD_DIV5;
      w0 = (seven ? 8'sd8 : 8'sd6) - 8'(signed'({1'b0, code}));
      w1 = 8'(signed'({1'b0, code})) - 8'sd1;
      acc = 24'(e0) * 24'(w0) + 24'(e1) * 24'(w1);
      if (acc < 0)
         acc = (acc - 24'(den) / 2) / 24'(den);
      else
         acc = (acc + 24'(den) / 2) / 24'(den);
      if (code == 3'h0)
         channel = e0;
      else if (code == 3'h1)
         channel = e1;
      else if (seven)
         channel = acc[15:0];
      else if (code == 3'h6)
         channel = sgn ? BTD_NEG_ONE : BTD_ZERO;
      else if (code == 3'h7)
         channel = BTD_ONE;
      else
         channel = acc[15:0];
   endfunction : channel

   // ==================================================================
   // State
   typedef struct packed
   {
      logic v;
      logic [63:0] rgba;
      logic [BTD_ADDR_W-1:0] off;
      logic [BTD_ADDR_W-1:0] size;
      logic [1:0] lx;
      logic [1:0] ly;
   } btd_top_s;
   btd_top_s st_r;
   btd_top_s st_nxt;
   logic fifo_in_ready; // FIFO space, stalls the request side
   logic [BTD_RES_W-1:0] fifo_out;
   logic fifo_out_valid;

   // Accept only when a result slot is sure to be free
   assign req_ready = fifo_in_ready && !st_r.v;

   // Next state: decode and address arithmetic
   always_comb
   begin
      logic [BTD_ADDR_W-1:0] bsz;
      logic sgn;
      logic signed [15:0] r;
      logic signed [15:0] g;
      // Locals start from known values so no path leaves a latch
      bsz = '0;
      sgn = 1'b0;
      r = '0;
      g = '0;
      st_nxt = st_r;
      bsz = addr_dual ? 32'(BTD_LARGE_BLOCK_BYTES)
         : 32'(BTD_SMALL_BLOCK_BYTES);
      // Outside-image texels decode like any other
      st_nxt.off = bsz * (32'(tiles(addr_width)) * 32'(addr_y >> 2)
         + 32'(addr_x >> 2));
      st_nxt.size = 32'(tiles(addr_width)) * 32'(tiles(addr_height)) * bsz;
      st_nxt.lx = addr_x[1:0];
      st_nxt.ly = addr_y[1:0];
      sgn = req_format[0];
      r = channel(req_block[63:0], sgn, req_local_x, req_local_y);
      if (req_format[1])
         g = channel(req_block[127:64], sgn, req_local_x,
            req_local_y);
      else
         g = BTD_ZERO;
      st_nxt.v = req_valid && req_ready;
      st_nxt.rgba = {r, g, BTD_ZERO, BTD_ONE};
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ==================================================================
   // Result buffering; consumer back-pressure reaches req_ready
   btd_fifo #(.WIDTH(BTD_RES_W), .DEPTH(BTD_FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rstn(rstn),
      .in_valid(st_r.v),
      .in_ready(fifo_in_ready),
      .in_data(st_r.rgba),
      .out_valid(fifo_out_valid),
      .out_ready(res_ready),
      .out_data(fifo_out)
   );
   assign res_valid = fifo_out_valid;
   assign res_red = fifo_out[63:48];
   assign res_green = fifo_out[47:32];
   assign res_blue = fifo_out[31:16];
   assign res_alpha = fifo_out[15:0];
   assign tile_offset = st_r.off;
   assign image_bytes = st_r.size;
   assign tile_local_x = st_r.lx;
   assign tile_local_y = st_r.ly;
endmodule : btd_decoder

// >>> verification/btd_decoder_props.sv
// Checker: handshake, latency and address properties of the decoder
`timescale 1ns/10ps
module btd_decoder_props
   import btd_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire logic [15:0] res_red,
   input wire logic [15:0] res_green,
   input wire logic [15:0] res_blue,
   input wire logic [15:0] res_alpha,
   input wire logic [BTD_DIM_W-1:0] addr_width,
   input wire logic [BTD_DIM_W-1:0] addr_height,
   input wire logic [BTD_DIM_W-1:0] addr_x,
   input wire logic [BTD_DIM_W-1:0] addr_y,
   input wire logic addr_dual,
   input wire logic [BTD_ADDR_W-1:0] tile_offset,
   input wire logic [BTD_ADDR_W-1:0] image_bytes,
   input wire logic [1:0] tile_local_x,
   input wire logic [1:0] tile_local_y
);
   // ==================================================================
   // Address figures from the present inputs
   logic [31:0] bs;
   logic [31:0] off_exp;
   logic [31:0] img_exp;
   logic [3:0] loc;
   always_comb
   begin
      bs = addr_dual ? 32'h10 : 32'h8;
      off_exp = bs * ((32'(addr_width) + 32'h3) / 32'h4
         * (32'(addr_y) / 32'h4) + 32'(addr_x) / 32'h4);
      img_exp = bs * ((32'(addr_width) + 32'h3) / 32'h4)
         * ((32'(addr_height) + 32'h3) / 32'h4);
      loc = {addr_x[1:0], addr_y[1:0]};
   end
   // ==================================================================
   // Properties
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   a_ready_gap: assert property (req_valid && req_ready |=> !req_ready)
      else $error("ready high right after a take");
   a_result_lat: assert property (req_valid && req_ready && !res_valid
      |-> ##2 res_valid) else $error("result late");
   a_res_hold: assert property (res_valid && !res_ready |=> res_valid
      && $stable(res_red) && $stable(res_green)) else $error("result moved");
   a_blue_zero: assert property (res_valid |-> res_blue == BTD_ZERO)
      else $error("blue not zero");
   a_alpha_one: assert property (res_valid |-> res_alpha == BTD_ONE)
      else $error("alpha not one");
   a_local_xy: assert property (1 |=> {tile_local_x, tile_local_y}
      == $past(loc)) else $error("local texel wrong");
   a_tile_addr: assert property (1 |=> tile_offset == $past(off_exp))
      else $error("tile offset wrong");
   a_image_size: assert property (1 |=> image_bytes == $past(img_exp))
      else $error("image size wrong");
endmodule : btd_decoder_props
bind btd_decoder btd_decoder_props u_props (.*);

// >>> verification/btd_sampler_model.sv
// Model of the texture sampler that consumes decoded texels
`timescale 1ns/10ps
module btd_sampler_model
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [1:0] mode,
   output logic res_ready
);
   // ==================================================================
   // Mode 0 prompt, 1 one pop in four cycles, 2 stalls to fill the FIFO
   logic [1:0] phase_r;
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_r <= 2'h0;
         res_ready <= 1'b0;
      end
      else
      begin
         phase_r <= phase_r + 2'h1;
         res_ready <= #1 mode == 2'h0 || (mode == 2'h1 && phase_r == 2'h3);
      end
   end
endmodule : btd_sampler_model

// >>> verification/btd_decoder_tb.sv
// Testbench: drives texel requests and address inputs, checks results
`timescale 1ns/10ps
module btd_decoder_tb
   import btd_pkg::*;
;
   logic clock = 0, rstn = 0, req_valid = 0, addr_dual = 0, res_ready;
   logic req_ready, res_valid;
   logic [127:0] req_block = '0;
   logic [1:0] req_format = 0, req_local_x = 0, req_local_y = 0, mode = 0;
   logic [15:0] res_red, res_green, res_blue, res_alpha;
   logic [BTD_DIM_W-1:0] addr_width = 0, addr_height = 0, addr_x = 0;
   logic [BTD_DIM_W-1:0] addr_y = 0;
   logic [31:0] tile_offset, image_bytes;
   logic [1:0] tile_local_x, tile_local_y;
   int fails = 0, checks = 0, n;
   logic [63:0] expq[$];
   // Selector vector: texel i carries code i mod 8; rows keep clear of
   // the -127/-128 pair except the last, which is deliberate
   localparam logic [47:0] S = 48'o7654321076543210;
   localparam logic [63:0] A = {S, 8'h40, 8'hC0}, B = {S, 8'hF0, 8'h10};
   logic [129:0] rows [9] = '{{2'h0, 64'h0, A}, {2'h0, 64'h0, B},
      {2'h1, 64'h0, A}, {2'h1, 64'h0, B}, {2'h2, B, A}, {2'h3, A, B},
      {2'h1, 64'h0, S, 16'h807F}, {2'h1, 64'h0, S, 16'h7F80},
      {2'h1, 64'h0, S, 16'h8081}};
   btd_decoder uut (.*);
   btd_sampler_model u_sampler (.*);
   initial forever #50 clock = ~clock;
   // ==================================================================
   // Reference decode, Q1.14 rounded half away from zero
   function automatic int rnd(int n, int d);
      return n >= 0 ? (2 * n + d) / (2 * d) : -((d - 2 * n) / (2 * d));
   endfunction : rnd
   function automatic int ep(logic [7:0] b, bit sg);
      if (!sg) return rnd(b * 16384, 255);
      return b == 8'h80 ? -16384 : rnd($signed(b) * 16384, 127);
   endfunction : ep
   function automatic logic [15:0] ch(logic [63:0] b, bit sg,
      logic [1:0] x, logic [1:0] y);
      int e0, e1, s, r;
      e0 = ep(b[7:0], sg);
      e1 = ep(b[15:8], sg);
      s = b[16 + 3 * (4 * y + x) +: 3];
      if (s < 2) r = s ? e1 : e0;
      else if (sg ? $signed(b[7:0]) > $signed(b[15:8]) : b[7:0] > b[15:8])
         r = rnd((8 - s) * e0 + (s - 1) * e1, 7);
      else if (s < 6) r = rnd((6 - s) * e0 + (s - 1) * e1, 5);
      else r = s == 7 ? 16384 : sg ? -16384 : 0;
      return r[15:0];
   endfunction : ch
   function automatic logic [63:0] exp_of(logic [129:0] rw,
      logic [1:0] x, logic [1:0] y);
      return {ch(rw[63:0], rw[128], x, y), rw[129] ? ch(rw[127:64],
         rw[128], x, y) : BTD_ZERO, BTD_ZERO, BTD_ONE};
   endfunction : exp_of
   // ==================================================================
   // Compare, count and report
   task automatic chk(string nm, logic [63:0] seen, logic [63:0] want);
      checks++;
      if (seen !== want)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   // Request held until ready is seen at an edge, then a gap cycle
   task automatic send(logic [129:0] rw, logic [1:0] x, logic [1:0] y);
      {req_format, req_block} = rw;
      req_local_x = x;
      req_local_y = y;
      req_valid = 1;
      while (req_ready !== 1'b1) @(posedge clock) #1;
      expq.push_back(exp_of(rw, x, y));
      @(posedge clock) #1 req_valid = 0;
      @(posedge clock) #1;
   endtask : send
   task automatic addr_case(logic [41:0] whxy, logic d, logic [63:0] want);
      {addr_width, addr_height, addr_x} = whxy;
      addr_y = 5;
      addr_dual = d;
      @(posedge clock) #1;
      chk("address", {tile_offset, image_bytes}, want);
      want = {2'(addr_x % 4), 2'(addr_y % 4)};
      chk("local", {tile_local_x, tile_local_y}, want);
   endtask : addr_case
   // Results checked before the edge that pops them
   always @(negedge clock)
      if (rstn === 1'b1 && res_valid === 1'b1 && res_ready === 1'b1)
         chk("texel", {res_red, res_green, res_blue, res_alpha},
            expq.pop_front());
   initial
   begin
      #2000000;
      fails++;
      close_out();
   end
   // ==================================================================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clock);
      chk("reset", {res_valid, req_ready, tile_offset}, 34'h100000000);
      #1 rstn = 1;
      foreach (rows[r])
      begin
         mode = {1'b0, r[0]};
         for (int t = 0; t < 16; t++) send(rows[r], t[1:0], t[3:2]);
      end
      addr_case({14'd10, 14'd7, 14'd9}, 0, {32'h28, 32'h30});
      addr_case({14'd8, 14'd8, 14'd7}, 1, {32'h30, 32'h40});
      mode = 2;
      {req_format, req_block} = rows[5];
      req_local_x = 0;
      req_local_y = 0;
      req_valid = 1;
      n = 0;
      repeat (40)
      begin
         if (req_ready === 1'b1) expq.push_back(exp_of(rows[5], 0, 0));
         if (req_ready === 1'b1) n++;
         @(posedge clock) #1;
      end
      req_valid = 0;
      chk("accepted", n, BTD_FIFO_DEPTH);
      mode = 0;
      repeat (200) @(posedge clock);
      chk("drained", {expq.size(), res_valid}, 0);
      close_out();
   end
endmodule : btd_decoder_tb
